// ### design/xor_exec_pkg.sv
package xor_exec_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int FILE_DEPTH = 128;

    // Opcode fields: literal form uses bits 13:8, file form bits 13:8 as well
    localparam logic [5:0] LIT_XOR_OPC = 6'h3A;
    localparam logic [5:0] FILE_XOR_OPC = 6'h06;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;

endpackage : xor_exec_pkg

// ### design/file_reg_mem.sv
module file_reg_mem
    import xor_exec_pkg::*;
(
    input wire logic mclk,
    input wire logic [xor_exec_pkg::ADDR_W-1:0] rd_addr,
    output logic [xor_exec_pkg::DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [xor_exec_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [xor_exec_pkg::DATA_W-1:0] wr_data
);
    import xor_exec_pkg::*;

    logic [DATA_W-1:0] mem [FILE_DEPTH];

    // Registered read; no reset on storage, like a real register file array
    always_ff @(posedge mclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : file_reg_mem

// ### design/xor_instruction_execute.sv
module xor_instruction_execute
    import xor_exec_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [xor_exec_pkg::INSTR_W-1:0] instr,
    input wire logic ext_wr_en,
    input wire logic [xor_exec_pkg::ADDR_W-1:0] ext_wr_addr,
    input wire logic [xor_exec_pkg::DATA_W-1:0] ext_wr_data,
    output logic [xor_exec_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic busy,
    output logic done,
    output logic [xor_exec_pkg::DATA_W-1:0] file_rd_data
);
    import xor_exec_pkg::*;

    // Instruction is taken in one cycle, the file read costs one more.
    typedef enum logic [0:0] {IDLE, EXEC} state_t;

    // What the current word asks for; anything else passes untouched
    typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_FILE} op_kind_t;

    typedef enum logic [0:0] {TO_ACC, TO_FILE} dest_t;

    typedef struct packed {
        state_t state;
        logic [DATA_W-1:0] acc;
        logic zero;
        logic done;
        dest_t dest;
        logic [ADDR_W-1:0] addr;
    } core_t;

    // Only the core state is cleared; file storage keeps its contents
    localparam core_t CORE_RESET = '{
        state: IDLE,
        acc: ACC_RESET,
        zero: ZERO_RESET,
        done: 1'b0,
        dest: TO_ACC,
        addr: '0
    };

    function automatic logic [5:0] opcode_of
    (
        input logic [INSTR_W-1:0] w
    );
        return w[OPC_MSB:OPC_LSB];
    endfunction : opcode_of

    function automatic logic [DATA_W-1:0] literal_of
    (
        input logic [INSTR_W-1:0] w
    );
        return w[DATA_W-1:0];
    endfunction : literal_of

    function automatic logic [ADDR_W-1:0] file_addr_of
    (
        input logic [INSTR_W-1:0] w
    );
        return w[ADDR_W-1:0];
    endfunction : file_addr_of

    function automatic dest_t dest_of
    (
        input logic [INSTR_W-1:0] w
    );
        return dest_t'(w[DEST_BIT]);
    endfunction : dest_of

    function automatic logic [DATA_W-1:0] xor_of
    (
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b
    );
        return a ^ b;
    endfunction : xor_of

    function automatic logic is_zero
    (
        input logic [DATA_W-1:0] v
    );
        return v == '0;
    endfunction : is_zero

    function automatic op_kind_t decode_kind
    (
        input logic [INSTR_W-1:0] w
    );
        op_kind_t k;
        unique case (opcode_of(w))
            LIT_XOR_OPC:
            begin
                k = OP_LIT;
            end
            FILE_XOR_OPC:
            begin
                k = OP_FILE;
            end
            default:
            begin
                k = OP_NONE;
            end
        endcase
        return k;
    endfunction : decode_kind

    core_t st_reg;
    core_t st_next;
    op_kind_t kind;

    logic [DATA_W-1:0] rd_data;
    logic [ADDR_W-1:0] rd_addr;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] lit_result;
    logic [DATA_W-1:0] file_result;

    assign kind = decode_kind(instr);
    // The read address follows the live word so the operand is ready one edge after taking
    assign rd_addr = file_addr_of(instr);
    assign lit_result = xor_of(st_reg.acc, literal_of(instr));
    // Operand is the registered read launched at the taking edge
    assign file_result = xor_of(st_reg.acc, rd_data);

    file_reg_mem u_mem (
        .mclk(mclk),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        mem_wr = ext_wr_en;
        mem_waddr = ext_wr_addr;
        mem_wdata = ext_wr_data;
        unique case (st_reg.state)
            IDLE:
            begin
                if (instr_valid)
                begin
                    unique case (kind)
                        OP_LIT:
                        begin
                            st_next.acc = lit_result;
                            // Only the zero flag moves; no other status bit lives here
                            st_next.zero = is_zero(lit_result);
                            st_next.done = 1'b1;
                        end
                        OP_FILE:
                        begin
                            st_next.dest = dest_of(instr);
                            st_next.addr = file_addr_of(instr);
                            st_next.state = EXEC;
                        end
                        OP_NONE:
                        begin
                            st_next.done = 1'b0;
                        end
                    endcase
                end
            end
            EXEC:
            begin
                // Words arriving now are dropped, not queued
                st_next.zero = is_zero(file_result);
                unique case (st_reg.dest)
                    TO_FILE:
                    begin
                        // Core write wins over an external write in the same slot
                        mem_wr = 1'b1;
                        mem_waddr = st_reg.addr;
                        mem_wdata = file_result;
                    end
                    TO_ACC:
                    begin
                        st_next.acc = file_result;
                    end
                endcase
                st_next.done = 1'b1;
                st_next.state = IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_reg <= CORE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign acc = st_reg.acc;
    assign zero_flag = st_reg.zero;
    assign done = st_reg.done;
    assign busy = st_reg.state == EXEC;
    assign file_rd_data = rd_data;

endmodule : xor_instruction_execute

// ### tb/xor_exec_sva.sv
module xor_exec_sva
    import xor_exec_pkg::*;
(
    input logic mclk,
    input logic rst,
    input logic instr_valid,
    input logic [INSTR_W-1:0] instr,
    input logic [DATA_W-1:0] acc,
    input logic zero_flag,
    input logic busy,
    input logic done,
    input logic [DATA_W-1:0] file_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic lit = instr_valid && !busy && instr[13:8] == LIT_XOR_OPC;
    wire logic fil = instr_valid && !busy && instr[13:8] == FILE_XOR_OPC;
    sequence exec_s;
        busy ##1 (!busy && done);
    endsequence
    a_lit_result: assert property (lit |=> acc == ($past(acc) ^ $past(instr[7:0])))
        else $error("literal result wrong");
    a_lit_flags: assert property (lit |=> done && !busy && zero_flag == (acc == 8'h00))
        else $error("literal flags wrong");
    a_file_steps: assert property (fil |=> exec_s)
        else $error("file sequence wrong");
    a_dest_clr: assert property (fil && !instr[7] |=>
        ##1 acc == ($past(acc, 2) ^ $past(file_rd_data)))
        else $error("file to acc wrong");
    a_dest_set: assert property (fil && instr[7] |=> ##1 acc == $past(acc, 2))
        else $error("acc not held");
    a_file_zero: assert property (fil |=>
        ##1 zero_flag == (($past(acc, 2) ^ $past(file_rd_data)) == 8'h00))
        else $error("file zero wrong");
endmodule : xor_exec_sva

bind xor_instruction_execute xor_exec_sva chk (.mclk, .rst, .instr_valid, .instr, .acc,
    .zero_flag, .busy, .done, .file_rd_data);

// ### tb/xor_instruction_execute_test.sv
module xor_instruction_execute_test;
    timeunit 1ns;
    timeprecision 1ns;
    import xor_exec_pkg::*;
    logic mclk = 1'h0, rst = 1'h1, instr_valid = 1'h0, ext_wr_en = 1'h0, zero_flag, busy, done;
    logic [13:0] instr = 14'h0000;
    logic [6:0] ext_wr_addr = 7'h00;
    logic [7:0] ext_wr_data = 8'h00, acc, file_rd_data;
    int num_errors = 0, n_tests = 0;
    xor_instruction_execute uut (.mclk, .rst, .instr_valid, .instr, .ext_wr_en, .ext_wr_addr,
        .ext_wr_data, .acc, .zero_flag, .busy, .done, .file_rd_data);
    always #20 mclk = ~mclk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Two cycles per word: the file form finishes and valid is low for one edge
    task automatic op(input logic [13:0] w);
        instr = w;
        instr_valid = 1'h1;
        @(negedge mclk);
        instr_valid = 1'h0;
        @(negedge mclk);
    endtask : op
    task automatic preload(input logic [6:0] a, input logic [7:0] d);
        ext_wr_en = 1'h1;
        ext_wr_addr = a;
        ext_wr_data = d;
        @(negedge mclk);
        ext_wr_en = 1'h0;
    endtask : preload
    task automatic t_lit;
        op({LIT_XOR_OPC, 8'hB5});
        op({LIT_XOR_OPC, 8'hAF});
        chk("acc", 8'h1A, acc);
        chk("zero", 8'h00, {7'h00, zero_flag});
        op({LIT_XOR_OPC, 8'h1A});
        chk("zero", 8'h01, {7'h00, zero_flag});
        $display("literal test done");
    endtask : t_lit
    task automatic t_file;
        preload(7'h05, 8'hAF);
        op({LIT_XOR_OPC, 8'hB5});
        op({FILE_XOR_OPC, 8'h85});
        chk("acc", 8'hB5, acc);
        op({FILE_XOR_OPC, 8'h05});
        chk("acc", 8'hAF, acc);
        chk("file", 8'h1A, file_rd_data);
        preload(7'h06, 8'hAF);
        op({FILE_XOR_OPC, 8'h06});
        chk("acc", 8'h00, acc);
        chk("zero", 8'h01, {7'h00, zero_flag});
        $display("file test done");
    endtask : t_file
    // A word offered while the file form is busy must be dropped
    task automatic t_refuse;
        instr = {FILE_XOR_OPC, 8'h06};
        instr_valid = 1'h1;
        @(negedge mclk);
        chk("busy", 8'h01, {7'h00, busy});
        instr = {LIT_XOR_OPC, 8'h55};
        @(negedge mclk);
        instr_valid = 1'h0;
        @(negedge mclk);
        chk("acc", 8'hAF, acc);
        op({6'h0E, 8'h05});
        chk("acc", 8'hAF, acc);
        $display("refuse test done");
    endtask : t_refuse
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (12) @(negedge mclk);
        rst = 1'h0;
        t_lit;
        t_file;
        t_refuse;
        results;
    end
    initial
    begin
        #10000;
        num_errors++;
        results;
    end
endmodule : xor_instruction_execute_test
